// file: common/ba_cfg.svh
// Register offsets, field positions and reset values of the backward-alarm unit.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef BA_CFG_SVH
`define BA_CFG_SVH

`define BA_ADDR_W 8
`define BA_NUM_ALARM 4
`define BA_NUM_EVT 5

`define BA_OFS_CTRL 8'h00
`define BA_OFS_STATUS 8'h04
`define BA_OFS_IRQ_STAT 8'h08
`define BA_OFS_IRQ_MASK 8'h0C

`define BA_CTRL_SRC_LSB 0
`define BA_CTRL_SVC_LSB 2
`define BA_CTRL_W 4
`define BA_CTRL_RST 4'h0

`define BA_ST_IN_LSB 0
`define BA_ST_ALM_LSB 4
`define BA_ST_RXF_BIT 8
`define BA_ST_PIN_BIT 9
`define BA_ST_DEF_BIT 10

`define BA_IRQ_RXF_BIT 4
`define BA_MASK_RST 5'h00

`define BA_SYNC_RST 4'hF

`define BA_RESP_OKAY 2'h0
`define BA_RESP_SLVERR 2'h2

`endif

// file: common/ba_pkg.sv
// Types shared by the backward-alarm unit and its register bus slave.
// Assumes ba_cfg.svh is on the include path.
`include "ba_cfg.svh"

package ba_pkg;

   typedef enum logic [1:0] {SRC_EEEE, SRC_AEEE, SRC_A000, SRC_AAAA} src_mode_t;
   typedef enum logic [1:0] {SVC_IDR, SVC_IBS, SVC_IBS_MULTI} service_t;
   typedef enum logic [1:0] {SEL_EXT, SEL_AUTO, SEL_OK} src_sel_t;

   typedef struct packed {
      service_t service;
      src_mode_t src_mode;
   } alarm_cfg_t;

   typedef struct packed {
      logic [`BA_NUM_ALARM-1:0] energise;
      logic [`BA_NUM_ALARM-1:0] no_closed;
      logic [`BA_NUM_ALARM-1:0] nc_closed;
   } relay_t;

   typedef struct packed {
      logic wr;
      logic [`BA_ADDR_W-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic rd;
      logic [`BA_ADDR_W-1:0] raddr;
   } reg_req_t;

   function automatic logic addr_hit(input logic [`BA_ADDR_W-1:0] a);
      addr_hit = (a == `BA_OFS_CTRL) || (a == `BA_OFS_STATUS) ||
                 (a == `BA_OFS_IRQ_STAT) || (a == `BA_OFS_IRQ_MASK);
   endfunction : addr_hit

endpackage : ba_pkg

// file: hdl/ba_sync.sv
// Two-stage synchroniser for a group of level inputs.
// Assumes the inputs are slow levels; a pulse shorter than one clock can be lost.
`timescale 1ns/1ns
`include "ba_cfg.svh"

module ba_sync
   import ba_pkg::*;
#(
   parameter int W = `BA_NUM_ALARM,
   parameter logic [W-1:0] RST_VAL = '1
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // Only the second stage is seen outside, so nothing samples a metastable value.
   always_comb
   begin
      next_st.meta = d;
      next_st.stable = st.meta;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         st <= '{meta: RST_VAL, stable: RST_VAL};
      else
         st <= next_st;
   end

   assign q = st.stable;

endmodule : ba_sync

// file: hdl/ba_axil_slave.sv
// AXI4-Lite slave front end: takes one write and one read at a time and hands
// them to the register file as single-cycle strobes.
// Assumes the register file answers a read combinationally in the strobe cycle.
`timescale 1ns/1ns
`include "ba_cfg.svh"

module ba_axil_slave
   import ba_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Write channels
   input wire logic [`BA_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels
   input wire logic [`BA_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Register file side
   output reg_req_t req,
   input wire logic [31:0] rdata
);

   typedef struct packed {
      logic aw_held;
      logic [`BA_ADDR_W-1:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_state_t;

   axil_state_t st;
   axil_state_t next_st;
   logic do_wr;
   logic do_rd;

   assign s_axi_awready = !st.aw_held;
   assign s_axi_wready = !st.w_held;
   assign s_axi_arready = !st.rvalid;
   assign do_wr = st.aw_held && st.w_held && !st.bvalid;
   assign do_rd = s_axi_arvalid && !st.rvalid;

   always_comb
   begin
      next_st = st;
      if (s_axi_awvalid && !st.aw_held)
      begin
         next_st.aw_held = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_held)
      begin
         next_st.w_held = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (do_wr)
      begin
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = addr_hit(st.awaddr) ? `BA_RESP_OKAY : `BA_RESP_SLVERR;
      end
      else if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;
      if (do_rd)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rdata;
         next_st.rresp = addr_hit(s_axi_araddr) ? `BA_RESP_OKAY : `BA_RESP_SLVERR;
      end
      else if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         st <= '0;
      else
         st <= next_st;
   end

   always_comb
   begin
      req.wr = do_wr;
      req.waddr = st.awaddr;
      req.wdata = st.wdata;
      req.wstrb = st.wstrb;
      req.rd = do_rd;
      req.raddr = s_axi_araddr;
   end

   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;

endmodule : ba_axil_slave

// file: hdl/backward_alarm_logic.sv
// Backward-alarm unit: four far-end alarm inputs, source selection per input,
// four alarm relays, a deferred summary alarm and an open-collector receive
// summary fault output, with registers and an interrupt over AXI4-Lite.
// Assumes alarm inputs and the receive-fail level arrive as slow levels.
`timescale 1ns/1ns
`include "ba_cfg.svh"

// Contract
// R1 - Each alarm output shows its normally-open contact open and normally-closed contact closed when healthy, swapped in alarm.
// R2 - Alarm relays are de-energised when healthy and energised only in alarm.
// R3 - The deferred summary alarm goes to alarm on any far-end alarm and is held energised while healthy; the code resets it de-energised.
// R4 - An alarm input at high level or floating means good and pulled to ground means fail.
// R5 - The receive summary fault pin is pulled low while a receive fault exists and released otherwise.
// R6 - Each alarm source is external, automatic from receive-fail, or forced good.
// R7 - Exactly four source combinations exist: EEEE, AEEE, A000 and AAAA.
// R8 - In intermediate-data-rate service the four channels are the four standard far-end alarms.
// R9 - In business service only alarm one is used and mirrored on the deferred alarm, unless the multidestination option keeps four.
// R10 - External wiring routes the receive summary fault and other fail outputs to the chosen alarm inputs.
// R11 - Unused alarm inputs are left unconnected, never grounded.
// R12 - Each alarm input passes a two-stage synchroniser before use.
module backward_alarm_logic
   import ba_pkg::*;
#(
   parameter int NUM_ALARM = `BA_NUM_ALARM
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // AXI4-Lite write channels
   input wire logic [`BA_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [`BA_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Alarm inputs, low means fail
   input wire logic [NUM_ALARM-1:0] alarm_in_n,
   // Internal receive-fail condition from the demodulator
   input wire logic rx_fail,
   // Receive summary fault open-collector pin
   input wire logic rx_fault_pin_i,
   output logic rx_fault_pin_o,
   output logic rx_fault_pin_oe,
   // Alarm relays and deferred summary alarm
   output relay_t relay,
   output logic deferred_energise,
   // Interrupt
   output logic irq
);

   typedef struct packed {
      alarm_cfg_t cfg;
      logic [`BA_NUM_EVT-1:0] irq_mask;
      logic [`BA_NUM_EVT-1:0] irq_stat;
      logic [NUM_ALARM-1:0] alarm;
      logic rx_fault;
      relay_t relay;
      logic deferred_energise;
      logic irq;
   } ba_state_t;

   ba_state_t st;
   ba_state_t next_st;
   reg_req_t req;
   logic [31:0] rdata;
   logic [NUM_ALARM-1:0] in_sync;
   logic [NUM_ALARM-1:0] ext_fail;
   logic [NUM_ALARM-1:0] raw_alarm;
   logic [NUM_ALARM-1:0] alarm;

   // Maps the source mode to the source of one channel; channel 0 is alarm one.
   function automatic src_sel_t src_sel(input src_mode_t mode, input int idx);
      src_sel = SEL_EXT;
      unique case (mode)
         SRC_EEEE: src_sel = SEL_EXT;
         SRC_AEEE: src_sel = (idx == 0) ? SEL_AUTO : SEL_EXT;
         SRC_A000: src_sel = (idx == 0) ? SEL_AUTO : SEL_OK;
         SRC_AAAA: src_sel = SEL_AUTO;
      endcase
   endfunction : src_sel

   // Applies the AXI byte strobes to an old register value.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            merge[8*b +: 8] = d[8*b +: 8];
      end
   endfunction : merge

   ba_axil_slave u_bus (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .req(req),
      .rdata(rdata)
   );

   // Floating inputs read high, so the synchroniser also resets to good.
   ba_sync #(
      .W(NUM_ALARM),
      .RST_VAL(NUM_ALARM'(`BA_SYNC_RST))
   ) u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .d(alarm_in_n),
      .q(in_sync)
   ); // R12

   assign ext_fail = ~in_sync; // R4

   always_comb
   begin
      raw_alarm = '0;
      for (int i = 0; i < NUM_ALARM; i++)
      begin
         unique case (src_sel(st.cfg.src_mode, i)) // R6 R7
            SEL_EXT: raw_alarm[i] = ext_fail[i];
            SEL_AUTO: raw_alarm[i] = rx_fail;
            SEL_OK: raw_alarm[i] = 1'b0;
            default: raw_alarm[i] = 1'b0;
         endcase
      end
   end

   // The service register field has a spare code; it behaves as the four-alarm service.
   always_comb
   begin
      alarm = raw_alarm; // R8
      unique case (st.cfg.service)
         SVC_IDR: alarm = raw_alarm; // R8
         SVC_IBS: alarm = {{(NUM_ALARM-1){1'b0}}, raw_alarm[0]}; // R9
         SVC_IBS_MULTI: alarm = raw_alarm; // R9
         default: alarm = raw_alarm;
      endcase
   end

   always_comb
   begin
      logic [`BA_NUM_EVT-1:0] evt;
      logic [`BA_NUM_EVT-1:0] clr;
      logic [31:0] wval;
      evt = '0;
      clr = '0;
      wval = '0;
      next_st = st;
      next_st.alarm = alarm;
      next_st.rx_fault = rx_fail;
      // Relays only pull in on alarm, so a dead supply reads as normal.
      next_st.relay.energise = alarm; // R2
      next_st.relay.no_closed = alarm; // R1
      next_st.relay.nc_closed = ~alarm; // R1
      // The summary is held energised while healthy, so a dead supply reads as fail.
      next_st.deferred_energise = ~(|alarm); // R3 R9
      evt[NUM_ALARM-1:0] = alarm & ~st.alarm;
      evt[`BA_IRQ_RXF_BIT] = rx_fail & ~st.rx_fault;
      if (req.rd && req.raddr == `BA_OFS_IRQ_STAT)
         clr = '1;
      // A new event in the clearing read cycle stays set.
      next_st.irq_stat = (st.irq_stat & ~clr) | evt;
      if (req.wr && req.waddr == `BA_OFS_CTRL)
      begin
         wval = merge({{(32-`BA_CTRL_W){1'b0}}, st.cfg}, req.wdata, req.wstrb);
         next_st.cfg.src_mode = src_mode_t'(wval[`BA_CTRL_SRC_LSB +: 2]); // R7
         next_st.cfg.service = service_t'(wval[`BA_CTRL_SVC_LSB +: 2]);
      end
      if (req.wr && req.waddr == `BA_OFS_IRQ_MASK)
      begin
         wval = merge({{(32-`BA_NUM_EVT){1'b0}}, st.irq_mask}, req.wdata, req.wstrb);
         next_st.irq_mask = wval[`BA_NUM_EVT-1:0];
      end
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= '0;
         st.cfg <= `BA_CTRL_RST;
         st.irq_mask <= `BA_MASK_RST;
         st.relay.nc_closed <= '1; // R1
      end
      else
         st <= next_st;
   end

   always_comb
   begin
      rdata = '0;
      unique case (req.raddr)
         `BA_OFS_CTRL: rdata[`BA_CTRL_W-1:0] = st.cfg;
         `BA_OFS_STATUS:
         begin
            rdata[`BA_ST_IN_LSB +: NUM_ALARM] = ext_fail;
            rdata[`BA_ST_ALM_LSB +: NUM_ALARM] = st.alarm;
            rdata[`BA_ST_RXF_BIT] = st.rx_fault;
            rdata[`BA_ST_PIN_BIT] = rx_fault_pin_i;
            rdata[`BA_ST_DEF_BIT] = st.deferred_energise;
         end
         `BA_OFS_IRQ_STAT: rdata[`BA_NUM_EVT-1:0] = st.irq_stat;
         `BA_OFS_IRQ_MASK: rdata[`BA_NUM_EVT-1:0] = st.irq_mask;
         default: rdata = '0;
      endcase
   end

   // Open collector: the pin only ever sinks; the far side pulls it up.
   assign rx_fault_pin_o = 1'b0; // R5
   assign rx_fault_pin_oe = st.rx_fault; // R5 R10
   assign relay = st.relay;
   assign deferred_energise = st.deferred_energise;
   assign irq = st.irq;

endmodule : backward_alarm_logic

// file: dv/ba_monitor.sv
// Concurrent checks on the relay, deferred alarm and fault pin outputs.
// Assumes it is bound to backward_alarm_logic and sees only its ports.
`timescale 1ns/1ns
`include "ba_cfg.svh"

module ba_monitor
   import ba_pkg::*;
#(
   parameter int NUM_ALARM = `BA_NUM_ALARM
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Watched ports
   input wire logic s_axi_wvalid,
   input wire logic [NUM_ALARM-1:0] alarm_in_n,
   input wire logic rx_fail,
   input wire logic rx_fault_pin_o,
   input wire logic rx_fault_pin_oe,
   input wire relay_t relay,
   input wire logic deferred_energise
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // A register write can change the source selection, so it counts as a cause too.
   sequence s_quiet;
      $stable(alarm_in_n) && $stable(rx_fail) && !s_axi_wvalid && $past(rstn, 3);
   endsequence
   sequence s_step;
      $changed(alarm_in_n) && $stable(rx_fail) && !s_axi_wvalid;
   endsequence
   property p_contacts;
      relay.nc_closed == ~relay.no_closed;
   endproperty
   a_contacts: assert property (p_contacts) else $error("contacts not complementary");
   property p_energise;
      relay.energise == relay.no_closed;
   endproperty
   a_energise: assert property (p_energise) else $error("coil and contact disagree");
   property p_deferred;
      $past(rstn) |-> deferred_energise == !(|relay.energise);
   endproperty
   a_deferred: assert property (p_deferred) else $error("deferred alarm wrong");
   property p_oe_on;
      $rose(rx_fail) |=> rx_fault_pin_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("fault pin not pulled");
   property p_oe_off;
      $fell(rx_fail) |=> !rx_fault_pin_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("fault pin not released");
   property p_pin_low;
      rx_fault_pin_oe |-> !rx_fault_pin_o;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("fault pin driven high");
   property p_settle;
      s_quiet [*4] |-> $stable(relay);
   endproperty
   a_settle: assert property (p_settle) else $error("relay moved without cause");
   // Two synchroniser stages plus the output register give a three-edge lag.
   property p_lag;
      s_quiet [*3] ##1 s_step |=> $stable(relay);
   endproperty
   a_lag: assert property (p_lag) else $error("alarm input reached relay too soon");
endmodule : ba_monitor

// file: dv/ba_station_model.sv
// Station wiring on the alarm connector: patch lead, equipment fail lines, pull-ups.
// Assumes the fault output is open collector, so only the pull-up makes its high level.
`timescale 1ns/1ns

module ba_station_model
(
   // Fault pin of the unit
   input wire logic rx_fault_pin_o,
   input wire logic rx_fault_pin_oe,
   // Station set-up
   input wire logic [3:0] ext_fail,
   input wire logic [3:0] wired,
   input wire logic [2:0] patch_sel,
   // Lines seen by the unit
   output logic [3:0] alarm_in_n,
   output logic rx_fault_pin_i
);
   always_comb
   begin
      rx_fault_pin_i = rx_fault_pin_oe ? rx_fault_pin_o : 1'h1;
      for (int i = 0; i < 4; i++)
      begin
         if (patch_sel == 3'(i + 1))
            alarm_in_n[i] = rx_fault_pin_i;
         else if (!wired[i])
            alarm_in_n[i] = 1'h1;
         else
            alarm_in_n[i] = !ext_fail[i];
      end
   end
endmodule : ba_station_model

// file: dv/testbench.sv
// Self-checking bench: registers, source modes, services, fault pin and interrupt.
// Assumes ba_station_model on the alarm connector and ba_monitor bound below.
`timescale 1ns/1ns
`include "ba_cfg.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
   $display("BAD t=%0t got %h want %h", $time, a, e); end end

module testbench
   import ba_pkg::*;
;
   localparam logic [33:0] all_bits = 34'h3FFFFFFFF;
   logic ref_clk, rstn, rx_fail, probe;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, alarm_in_n, ext_fail, wired, ctrl;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic rx_fault_pin_i, rx_fault_pin_o, rx_fault_pin_oe, deferred_energise, irq;
   logic [2:0] patch_sel;
   relay_t relay;
   logic [33:0] eq[$], cq[$], act, e, c;
   int n_errors, check_count;
   integer seed = 32'hD603A751;

   backward_alarm_logic #(.NUM_ALARM(4)) uut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alarm_in_n, .rx_fail, .rx_fault_pin_i,
      .rx_fault_pin_o, .rx_fault_pin_oe, .relay, .deferred_energise, .irq);
   ba_station_model station (.rx_fault_pin_o, .rx_fault_pin_oe, .ext_fail, .wired, .patch_sel,
      .alarm_in_n, .rx_fault_pin_i);

   always #2 ref_clk = ~ref_clk;

   function automatic logic [3:0] exp_alarm(input logic [3:0] k, input logic [3:0] n,
      input logic rf);
      logic [3:0] a;
      case (src_mode_t'(k[1:0]))
         SRC_EEEE: a = ~n;
         SRC_AEEE: a = {~n[3:1], rf};
         SRC_A000: a = {3'h0, rf};
         default: a = {4{rf}};
      endcase
      if (service_t'(k[3:2]) == SVC_IBS)
         a[3:1] = 3'h0;
      return a;
   endfunction : exp_alarm

   task automatic push(input logic [33:0] ev, input logic [33:0] cv);
      eq.push_back(ev);
      cq.push_back(cv);
   endtask : push

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] r);
      logic aw, w;
      @(posedge ref_clk);
      push({r, 32'h0}, {2'h3, 32'h0});
      aw = 1'h1;
      w = 1'h1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (aw || w)
      begin
         @(posedge ref_clk);
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      while (!s_axi_bvalid)
         @(posedge ref_clk);
      s_axi_bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] ev, input logic [33:0] cv);
      @(posedge ref_clk);
      push(ev, cv);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
         @(posedge ref_clk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      while (!s_axi_rvalid)
         @(posedge ref_clk);
      s_axi_rready <= 1'h0;
   endtask : rd

   // Probes the output levels and the status word against the expected alarm state.
   task automatic check_state(input logic irq_e, input logic irq_c);
      logic [3:0] a;
      a = exp_alarm(ctrl, alarm_in_n, rx_fail);
      @(posedge ref_clk);
      push({19'h0, irq_e, rx_fail, ~|a, a, a, ~a}, {19'h0, irq_c, 14'h3FFF});
      probe <= 1'h1;
      @(posedge ref_clk);
      probe <= 1'h0;
      rd(`BA_OFS_STATUS, {23'h0, ~|a, ~rx_fail, rx_fail, a, ~alarm_in_n}, all_bits);
   endtask : check_state

   task automatic report_and_stop();
      // Notes that never saw their answer count as mismatches.
      n_errors += eq.size();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   always @(posedge ref_clk)
   begin
      if (probe || (s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
      begin
         if (probe)
            act = {19'h0, irq, rx_fault_pin_oe, deferred_energise, relay};
         else if (s_axi_rvalid)
            act = {s_axi_rresp, s_axi_rdata};
         else
            act = {s_axi_bresp, 32'h0};
         e = eq.pop_front();
         c = cq.pop_front();
         `CHK(act & c, e)
      end
   end

   initial
   begin
      #200000;
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      {ref_clk, rstn, rx_fail, probe, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
      {s_axi_wstrb, ext_fail, patch_sel, ctrl} = 15'h0;
      wired = 4'hF;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'h1;
      rd(`BA_OFS_CTRL, 34'h0, all_bits);
      rd(`BA_OFS_IRQ_MASK, 34'h0, all_bits);
      check_state(1'h0, 1'h1);
      wr(8'h10, 32'h1, 4'hF, `BA_RESP_SLVERR);
      rd(8'h10, {`BA_RESP_SLVERR, 32'h0}, all_bits);
      wr(`BA_OFS_STATUS, 32'h3, 4'hF, `BA_RESP_OKAY);
      wr(`BA_OFS_CTRL, 32'hF, 4'h0, `BA_RESP_OKAY);
      rd(`BA_OFS_CTRL, 34'h0, all_bits);
      wr(`BA_OFS_CTRL, 32'hFFFFFFF5, 4'hF, `BA_RESP_OKAY);
      rd(`BA_OFS_CTRL, 34'h5, all_bits);
      for (int m = 0; m < 32; m++)
      begin
         ctrl = 4'(m);
         wr(`BA_OFS_CTRL, {28'h0, ctrl}, 4'hF, `BA_RESP_OKAY);
         // A quiet gap, then the pins alone, so the lag check sees a clean step.
         repeat (3) @(posedge ref_clk);
         ext_fail <= 4'($random(seed));
         wired <= 4'($random(seed));
         patch_sel <= 3'($random(seed));
         @(posedge ref_clk);
         rx_fail <= 1'($random(seed));
         repeat (6) @(posedge ref_clk);
         check_state(1'h0, 1'h0);
      end
      ctrl = 4'h0;
      wr(`BA_OFS_CTRL, 32'h0, 4'hF, `BA_RESP_OKAY);
      {ext_fail, patch_sel, rx_fail} <= 8'h0;
      wired <= 4'hF;
      repeat (6) @(posedge ref_clk);
      rd(`BA_OFS_IRQ_STAT, 34'h0, 34'h0);
      wr(`BA_OFS_IRQ_MASK, 32'h10, 4'hF, `BA_RESP_OKAY);
      ext_fail <= 4'h2;
      repeat (6) @(posedge ref_clk);
      check_state(1'h0, 1'h1);
      rx_fail <= 1'h1;
      repeat (6) @(posedge ref_clk);
      check_state(1'h1, 1'h1);
      rd(`BA_OFS_IRQ_STAT, 34'h12, all_bits);
      check_state(1'h0, 1'h1);
      // Let the watcher take the last answer before the verdict.
      repeat (2) @(posedge ref_clk);
      report_and_stop();
   end
endmodule : testbench

bind backward_alarm_logic ba_monitor #(.NUM_ALARM(NUM_ALARM)) mon (.ref_clk, .rstn,
   .s_axi_wvalid, .alarm_in_n, .rx_fail, .rx_fault_pin_o, .rx_fault_pin_oe, .relay,
   .deferred_energise);
